// ### design/asf_pkg.sv
// Shared constants and types for the serial frame link of the converter.
// Assumes a 100 MHz system clock on both ends.
package asf_pkg;
  // ==========================================================
  // Frame layout
  localparam int CMD_BITS = 16;   // Command bits per frame
  localparam int RES_BITS = 16;   // Result bits per device
  localparam int NCH = 8;         // Analog channels
  localparam int CHAN_W = 3;      // Channel field width
  localparam int CHAN_LSB = 0;    // Channel field position in a command
  localparam int FMT_POS = 8;     // Extended output format bit
  localparam int TAG_BITS = 4;    // Channel tag appended in extended format
  localparam int OUT_MAX = RES_BITS + TAG_BITS;
  localparam int CMD_EDGES = 16;  // Falling edges of the command phase
  localparam logic [CMD_BITS-1:0] CMD_RST = 16'h0000;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;     // System clock period
  localparam int T_CONV_NS = 1000; // Longest internal conversion time
  localparam int CONV_CYC = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_DIV = 4;    // Host half period in clocks
  // ==========================================================
  // State types
  typedef enum logic [0:0] {C_IDLE = 1'b0, C_CONV = 1'b1} asf_conv_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_HIGH = 3'b001,
    H_LOW = 3'b010,
    H_END = 3'b011,
    H_GAP = 3'b100
  } asf_host_t;
endpackage

// ### design/asf_link_if.sv
// Wires of one serial frame link between a host and a converter.
// The shared result line is pulled low when no one drives it.
`timescale 1ns/1ns
`default_nettype none
interface asf_link_if;
  logic cs_n;     // Chip select, active low
  logic sclk;     // Serial clock, made by the host
  logic cmd_sd;   // Command data to the device
  logic res_sd;   // Result data from the device
  logic res_oe;   // Device drives the result line
  logic chain_in; // Chain input of the device
  logic res_line; // Resolved level of the result line
  // Released line reads low through the pull-down
  assign res_line = res_oe & res_sd;
  modport dev(input cs_n, input sclk, input cmd_sd, input chain_in, output res_sd, output res_oe);
  modport host(output cs_n, output sclk, output cmd_sd, input res_line);
endinterface
`default_nettype wire

// ### design/asf_sync.sv
// Three-stage synchroniser with an agreement filter on the last two stages.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ns
`default_nettype none
module asf_sync #(
  parameter int STAGES = 3,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic d_i,
  output logic q_o
);
  logic [STAGES-1:0] s_r; // Shift chain, stage 0 first
  logic q_r;              // Filtered level
  // ==========================================================
  // Elaboration check
  if (STAGES != 3) begin : g_chk
    $error("asf_sync supports three stages only");
  end
  // ==========================================================
  // Shift chain; stage 0 only feeds stage 1
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= {STAGES{RST_VAL}};
    end else begin
      s_r <= {s_r[STAGES-2:0], d_i};
    end
  end
  // Change counts only when stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r <= RST_VAL;
    end else if (s_r[1] == s_r[2]) begin
      q_r <= s_r[2];
    end
  end
  assign q_o = q_r;
endmodule
`default_nettype wire

// ### design/asf_dev.sv
// Device end of the serial frame link: command capture, conversion timing,
// result shift register with chain input.
// Assumes clk_i is the internal oscillator and the host makes sclk.
// Behaviour
// [R1] Chip select fall samples, starts timed conversion
// [R2] Channel comes from previous frame's command
// [R3] Capture command bit each fall, 16 cycles
// [R4] Result line low for first 16 cycles
// [R5] Host lets conversion finish before 16th fall
// [R6] Last command bit at 16th fall, then ignore
// [R7] MSB at 16th fall, one bit per fall
// [R8] Zeros after last result bit
// [R9] Host raises chip select when done
// [R10] Result line released while chip select high
// [R11] Chaining needs no configuration
// [R12] Conversion end loads 16-bit result
// [R13] After 16th fall shift in chain input
// [R14] Host gets last device's word first
// [R15] Host gives 16 x N result falls
// [R16] Only one chip select low at once
// [R17] Configuration applies at next chip select fall
// [R18] Output length follows format setting
// [R19] First device shifts zeros behind result
`timescale 1ns/1ns
`default_nettype none
module asf_dev #(
  parameter int CONV_CYC = asf_pkg::CONV_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  asf_link_if.dev link,
  input wire logic [asf_pkg::NCH*asf_pkg::RES_BITS-1:0] sample_i,
  output logic [asf_pkg::CHAN_W-1:0] chan_o,
  output logic [asf_pkg::CMD_BITS-1:0] cmd_o,
  output logic cfg_pulse_o,
  output logic busy_o
);
  localparam int RB = asf_pkg::RES_BITS;
  localparam int OM = asf_pkg::OUT_MAX;
  localparam int CW = $clog2(CONV_CYC + 1);
  // ==========================================================
  // Elaboration check
  if (CONV_CYC < 1) begin : g_chk
    $error("conversion time must be at least one cycle");
  end
  // ==========================================================
  // Oscillator domain signals
  logic cs_sync;            // Filtered chip select
  logic cs_prev_r;          // Previous filtered chip select
  logic cs_fall;            // Frame start seen
  logic tog_sync;           // Synchronised command toggle
  logic seen_r;             // Last command toggle consumed
  logic [asf_pkg::CHAN_W-1:0] chan_r; // Active channel
  logic fmt_r;              // Extended output format
  logic [asf_pkg::CMD_BITS-1:0] cmd_r; // Applied command
  logic cfg_r;              // Command applied pulse
  asf_pkg::asf_conv_t cst_r; // Conversion state
  logic [CW-1:0] ccnt_r;    // Conversion cycles left
  logic [RB-1:0] samp_r;    // Held sample
  logic [RB-1:0] res_r;     // Finished result
  logic done_r;             // Result ready, level
  logic [asf_pkg::CHAN_W-1:0] chan_nxt; // Channel for this frame
  // ==========================================================
  // Link domain signals
  logic frame_rstn;         // Held in reset while deselected
  logic [4:0] ecnt_r;       // Falling edges in this frame, saturating
  logic [asf_pkg::CMD_BITS-1:0] csh_r; // Command shift register
  logic [asf_pkg::CMD_BITS-1:0] chold_r; // Complete command word
  logic ctog_r;             // Toggles on each complete command
  logic dn1_r;              // Done synchroniser, first stage
  logic dn2_r;              // Done synchroniser, second stage
  logic dn3_r;              // Done synchroniser, third stage
  logic dn_r;               // Filtered ready flag
  logic [OM-2:0] osh_r;     // Output shift register, word below its MSB
  logic [OM-2:0] osh_nxt;   // Next output shift value
  logic [OM-1:0] oword;     // Word loaded at the 16th fall
  logic sdo_r;              // Result line data
  // ==========================================================
  // Crossings into the oscillator domain
  asf_sync #(.STAGES(3), .RST_VAL(1'b1)) u_cs (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(link.cs_n),
    .q_o(cs_sync)
  );
  asf_sync #(.STAGES(3), .RST_VAL(1'b0)) u_tog (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(ctog_r),
    .q_o(tog_sync)
  );
  // Edge detect on the filtered chip select
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_sync;
    end
  end
  assign cs_fall = cs_prev_r & ~cs_sync;
  // Pending command word is stable since its 16th fall
  always_comb begin
    chan_nxt = chan_r;
    if (tog_sync != seen_r) begin
      chan_nxt = chold_r[asf_pkg::CHAN_LSB +: asf_pkg::CHAN_W];
    end
  end
  // ==========================================================
  // Configuration: applied only at a frame start
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_r <= 1'b0;
      chan_r <= '0;
      fmt_r <= 1'b0;
      cmd_r <= asf_pkg::CMD_RST;
      cfg_r <= 1'b0;
    end else begin
      cfg_r <= 1'b0;
      if (cs_fall && (tog_sync != seen_r)) begin // [R17]
        seen_r <= tog_sync;
        chan_r <= chan_nxt; // [R2]
        fmt_r <= chold_r[asf_pkg::FMT_POS];
        cmd_r <= chold_r;
        cfg_r <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Conversion timed by the oscillator, not by sclk
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cst_r <= asf_pkg::C_IDLE;
      ccnt_r <= '0;
      samp_r <= '0;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      case (cst_r)
        asf_pkg::C_IDLE: begin
          if (cs_fall) begin // [R1]
            samp_r <= sample_i[chan_nxt*RB +: RB]; // [R2]
            ccnt_r <= CW'(CONV_CYC - 1);
            done_r <= 1'b0;
            cst_r <= asf_pkg::C_CONV;
          end
        end
        asf_pkg::C_CONV: begin
          // A new frame start during conversion restarts it
          if (cs_fall) begin
            samp_r <= sample_i[chan_nxt*RB +: RB];
            ccnt_r <= CW'(CONV_CYC - 1);
          end else if (ccnt_r == '0) begin
            res_r <= samp_r; // [R12]
            done_r <= 1'b1;
            cst_r <= asf_pkg::C_IDLE;
          end else begin
            ccnt_r <= ccnt_r - 1'b1;
          end
        end
        default: begin
          cst_r <= asf_pkg::C_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // Link domain: everything moves on sclk falling edges
  assign frame_rstn = resetn_i & ~link.cs_n;
  // Edge counter of the frame, cleared while deselected
  always_ff @(negedge link.sclk or negedge frame_rstn) begin
    if (!frame_rstn) begin
      ecnt_r <= '0;
    end else if (ecnt_r != 5'(asf_pkg::CMD_EDGES)) begin
      ecnt_r <= ecnt_r + 1'b1;
    end
  end
  // Command capture; survives chip select so it can be applied later
  always_ff @(negedge link.sclk or negedge resetn_i) begin
    if (!resetn_i) begin
      csh_r <= asf_pkg::CMD_RST;
      chold_r <= asf_pkg::CMD_RST;
      ctog_r <= 1'b0;
    end else if (!link.cs_n && ecnt_r < 5'(asf_pkg::CMD_EDGES)) begin
      csh_r <= {csh_r[asf_pkg::CMD_BITS-2:0], link.cmd_sd}; // [R3]
      if (ecnt_r == 5'(asf_pkg::CMD_EDGES - 1)) begin
        chold_r <= {csh_r[asf_pkg::CMD_BITS-2:0], link.cmd_sd}; // [R6]
        ctog_r <= ~ctog_r;
      end
    end
  end
  // Three-stage level synchroniser for the ready flag; counts once stages two and three agree
  always_ff @(negedge link.sclk or negedge resetn_i) begin
    if (!resetn_i) begin
      dn1_r <= 1'b0;
      dn2_r <= 1'b0;
      dn3_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      dn1_r <= done_r;
      dn2_r <= dn1_r;
      dn3_r <= dn2_r;
      if (dn2_r == dn3_r) begin
        dn_r <= dn3_r;
      end
    end
  end
  // Word to send; without the ready flag the data is corrupt anyway
  always_comb begin
    oword = '0;
    if (dn_r) begin // [R5]
      oword = {res_r, fmt_r ? {1'b0, chan_r} : 4'h0}; // [R18]
    end
  end
  // Shift with chain input; short format inserts it behind bit 16
  always_comb begin
    osh_nxt = {osh_r[OM-3:0], link.chain_in}; // [R13]
    if (!fmt_r) begin
      osh_nxt[asf_pkg::TAG_BITS] = link.chain_in; // [R18]
    end
  end
  // Output shift register, cleared while deselected
  always_ff @(negedge link.sclk or negedge frame_rstn) begin
    if (!frame_rstn) begin
      osh_r <= '0;
      sdo_r <= 1'b0;
    end else if (ecnt_r < 5'(asf_pkg::CMD_EDGES - 1)) begin
      sdo_r <= 1'b0; // [R4]
    end else if (ecnt_r == 5'(asf_pkg::CMD_EDGES - 1)) begin
      sdo_r <= oword[OM-1]; // [R7]
      // The MSB leaves now and is not stored, so the chain bit of fall 17 follows the word directly
      osh_r <= oword[OM-2:0];
    end else begin
      // Tied-low chain input refills with zeros
      sdo_r <= osh_r[OM-2]; // [R8] [R19] [R14]
      osh_r <= osh_nxt; // [R11]
    end
  end
  // ==========================================================
  // Outputs
  assign link.res_sd = sdo_r;
  assign link.res_oe = ~link.cs_n; // [R10]
  assign chan_o = chan_r;
  assign cmd_o = cmd_r;
  assign cfg_pulse_o = cfg_r;
  assign busy_o = (cst_r == asf_pkg::C_CONV);
endmodule
`default_nettype wire

// ### design/asf_host.sv
// Host end of the serial frame link: makes chip select and sclk, sends one
// command per frame and collects the results of a chain of devices.
// Assumes clk_i at 100 MHz; sclk is derived by a divider.
`timescale 1ns/1ns
`default_nettype none
module asf_host #(
  parameter int N_DEV = 1,
  parameter int WORD_BITS = asf_pkg::RES_BITS,
  parameter int DIV = asf_pkg::SCLK_DIV
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  asf_link_if.host link,
  input wire logic start_i,
  input wire logic [asf_pkg::CMD_BITS-1:0] cmd_i,
  output logic ready_o,
  output logic [N_DEV*WORD_BITS-1:0] data_o,
  output logic done_o
);
  localparam int TOTAL = asf_pkg::CMD_EDGES + N_DEV * WORD_BITS;
  localparam int FW = $clog2(TOTAL + 1);
  localparam int DW = $clog2(DIV + 1);
  // ==========================================================
  // Elaboration checks: sync latency and conversion time
  if (DIV < 4 || N_DEV < 1) begin : g_chk
    $error("divider below 4 or empty chain");
  end
  if (31 * DIV <= asf_pkg::CONV_CYC) begin : g_conv
    $error("sclk too fast for the conversion time");
  end
  // ==========================================================
  // Signals
  asf_pkg::asf_host_t st_r;  // Frame state
  logic [DW-1:0] div_r;      // Half period counter
  logic [FW-1:0] fcnt_r;     // Falling edges made
  logic [asf_pkg::CMD_BITS-1:0] csh_r; // Command still to send
  logic [N_DEV*WORD_BITS-1:0] dsh_r;   // Received bits
  logic [N_DEV*WORD_BITS-1:0] dat_r;   // Last complete frame
  logic cs_n_r;              // Chip select
  logic sclk_r;              // Serial clock, idles high
  logic done_r;              // Frame finished pulse
  logic sdo_sync;            // Result line in clk_i domain
  logic half_end;            // Half period elapsed
  // ==========================================================
  // Result line crosses from the device
  asf_sync #(.STAGES(3), .RST_VAL(1'b0)) u_sdo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i(link.res_line),
    .q_o(sdo_sync)
  );
  assign half_end = (div_r == DW'(DIV - 1));
  // Half period divider, restarted by every state change
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= '0;
    end else if (st_r == asf_pkg::H_IDLE || half_end) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= asf_pkg::H_IDLE;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b1;
      fcnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        asf_pkg::H_IDLE: begin
          if (start_i) begin
            cs_n_r <= 1'b0;
            fcnt_r <= '0;
            st_r <= asf_pkg::H_HIGH;
          end
        end
        asf_pkg::H_HIGH: begin
          if (half_end) begin
            sclk_r <= 1'b0;
            fcnt_r <= fcnt_r + 1'b1;
            st_r <= asf_pkg::H_LOW;
          end
        end
        asf_pkg::H_LOW: begin
          if (half_end) begin
            sclk_r <= 1'b1;
            // 16 command falls plus 16 x N result falls
            st_r <= (fcnt_r == FW'(TOTAL)) ? asf_pkg::H_END : asf_pkg::H_HIGH; // [R15]
          end
        end
        asf_pkg::H_END: begin
          if (half_end) begin
            cs_n_r <= 1'b1; // [R9]
            done_r <= 1'b1;
            st_r <= asf_pkg::H_GAP;
          end
        end
        asf_pkg::H_GAP: begin
          // Deselect gap; also keeps one chip select low at a time
          if (half_end) begin
            st_r <= asf_pkg::H_IDLE; // [R16]
          end
        end
        default: begin
          st_r <= asf_pkg::H_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // Command out: changes on rising edges, idles low after 16 bits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      csh_r <= asf_pkg::CMD_RST;
    end else if (st_r == asf_pkg::H_IDLE && start_i) begin
      csh_r <= cmd_i;
    end else if (st_r == asf_pkg::H_LOW && half_end) begin
      csh_r <= {csh_r[asf_pkg::CMD_BITS-2:0], 1'b0};
    end
  end
  // Result in: bit from fall k taken just before fall k+1
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dsh_r <= '0;
      dat_r <= '0;
    end else begin
      if (st_r == asf_pkg::H_HIGH && half_end && fcnt_r >= FW'(asf_pkg::CMD_EDGES)) begin
        dsh_r <= {dsh_r[N_DEV*WORD_BITS-2:0], sdo_sync}; // [R7]
      end
      if (st_r == asf_pkg::H_END && half_end) begin
        dat_r <= dsh_r; // [R14]
      end
    end
  end
  // ==========================================================
  // Outputs
  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.cmd_sd = csh_r[asf_pkg::CMD_BITS-1];
  assign ready_o = (st_r == asf_pkg::H_IDLE);
  assign data_o = dat_r;
  assign done_o = done_r;
endmodule
`default_nettype wire

// ### sim/asf_link_monitor.sv
// Checker of the serial frame link wires between one host and one device.
// Assumes both ends share clk_i and the host holds each sclk half for 4 clocks.
`timescale 1ns/1ns
`default_nettype none
module asf_link_monitor #(
  parameter int NFALL = 32
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic cmd_sd,
  input wire logic res_sd,
  input wire logic res_oe,
  input wire logic chain_in,
  input wire logic res_line
);
  // ==========================================================
  // Frame tracking
  logic [7:0] fcnt_r; // Falls seen so far in this frame
  logic [15:0] cmd_sh_r; // Command bits of this frame
  logic [3:0] nxt_cfg_r; // Format and channel waiting for the next frame
  logic [3:0] cfg_r; // Format and channel of this frame
  logic [19:0] chh_r; // Chain input history, newest in bit 0
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Fall counter, cleared while deselected; saturates so it never wraps
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fcnt_r <= 8'h00;
    end else if (cs_n) begin
      fcnt_r <= 8'h00;
    end else if ($fell(sclk) && fcnt_r != 8'hFF) begin
      fcnt_r <= fcnt_r + 8'h01;
    end
  end
  // Command bits only in the first 16 falls; chain bits on every fall
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_sh_r <= 16'h0000;
      chh_r <= 20'h00000;
    end else if (!cs_n && $fell(sclk)) begin
      if (fcnt_r < 8'h10)
        cmd_sh_r <= {cmd_sh_r[14:0], cmd_sd};
      chh_r <= {chh_r[18:0], chain_in};
    end
  end
  // A complete command waits for the next frame start; a short frame keeps the old one
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nxt_cfg_r <= 4'h0;
      cfg_r <= 4'h0;
    end else begin
      if ($rose(cs_n) && fcnt_r >= 8'h10)
        nxt_cfg_r <= {cmd_sh_r[8], cmd_sh_r[2:0]};
      if ($fell(cs_n))
        cfg_r <= nxt_cfg_r;
    end
  end
  // ==========================================================
  // Assertions
  a_oe_follows_cs: assert property (res_oe == !cs_n && (!cs_n || !res_line))
    else $error("result line driven outside a frame");
  a_low_cmd_phase: assert property ($fell(sclk) && !cs_n && fcnt_r < 8'h0F |-> !res_sd)
    else $error("result line not low in command phase");
  a_bit_per_fall: assert property (!cs_n && !$fell(sclk) && !$fell(cs_n) |-> $stable(res_sd))
    else $error("result line changed between falls");
  a_chain_order: assert property ($fell(sclk) && !cs_n && fcnt_r >= (cfg_r[3] ? 8'h23 : 8'h1F) |->
    res_sd == (cfg_r[3] ? chh_r[18] : chh_r[14]))
    else $error("chain bit out of place");
  a_tag_field: assert property ($fell(sclk) && !cs_n && cfg_r[3] && fcnt_r >= 8'h1F && fcnt_r <= 8'h22 |->
    res_sd == ((fcnt_r == 8'h1F) ? 1'b0 : cfg_r[8'h22 - fcnt_r]))
    else $error("channel tag wrong");
  a_frame_length: assert property ($rose(cs_n) |-> int'(fcnt_r) >= NFALL)
    else $error("frame too short for the chain");
  a_sclk_spacing: assert property ($fell(sclk) |=> !sclk [*3] ##1 sclk)
    else $error("serial clock low phase wrong");
  a_sclk_idle: assert property (cs_n |-> sclk)
    else $error("serial clock moved outside a frame");
  a_cmd_setup: assert property ($fell(sclk) |-> $stable(cmd_sd))
    else $error("command data changed at a fall");
  c_ext_frame: cover property ($rose(cs_n) && cfg_r[3]);
  c_short_frame: cover property ($rose(cs_n) && !cfg_r[3]);
  c_chain_one: cover property ($fell(sclk) && fcnt_r == 8'h20 && res_sd);
endmodule
`default_nettype wire

// ### sim/adc_serial_frame_daisy_chain_test.sv
// Testbench: one host and one device joined by a link, results checked against a model.
// Assumes both ends run on the 100 MHz clock; the bench feeds a pattern to the chain input.
`timescale 1ns/1ns
`default_nettype none
module adc_serial_frame_daisy_chain_test;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic resetn_i = 1'b1; // Falls at time 0 so every reset branch runs, sclk-clocked ones too
  logic start_i = 1'b0;
  logic [15:0] cmd_i = 16'h0000;
  logic [127:0] sample_i = 128'h0;
  logic [31:0] data_o;
  logic ready_o, done_o, busy_o, cfg_pulse_o;
  int cfg_seen = 0; // Configuration pulses seen
  int cfg_want = 0; // Configuration pulses expected
  logic have_prev = 1'b0; // A full command went out since the last reset
  logic [2:0] chan_o;
  logic [15:0] cmd_o;
  logic [15:0] ch16 = 16'h0000; // Bits fed to the chain input on falls 17 to 32
  logic [15:0] prev_cmd = 16'h0000; // Command that the next frame start applies
  logic [66:0] exp_q[$]; // Data, channel and command expected at each done
  logic [66:0] got_e;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int fcnt = 0; // Falls of the current frame
  always #5 clk_i = ~clk_i;
  asf_link_if lnk();
  asf_host #(.N_DEV(2)) asf_host_i(.clk_i(clk_i), .resetn_i(resetn_i), .link(lnk), .start_i(start_i),
    .cmd_i(cmd_i), .ready_o(ready_o), .data_o(data_o), .done_o(done_o));
  asf_dev #(.CONV_CYC(20)) asf_dev_i(.clk_i(clk_i), .resetn_i(resetn_i), .link(lnk), .sample_i(sample_i),
    .chan_o(chan_o), .cmd_o(cmd_o), .cfg_pulse_o(cfg_pulse_o), .busy_o(busy_o));
  asf_link_monitor #(.NFALL(48)) asf_link_monitor_i(.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .cmd_sd(lnk.cmd_sd), .res_sd(lnk.res_sd), .res_oe(lnk.res_oe),
    .chain_in(lnk.chain_in), .res_line(lnk.res_line));
  // ==========================================================
  // Chain input: changed on rising sclk so it is settled at the next fall
  initial lnk.chain_in = 1'b0;
  always @(negedge lnk.sclk or posedge lnk.cs_n) fcnt <= lnk.cs_n ? 0 : fcnt + 1;
  always @(posedge lnk.sclk) lnk.chain_in <= (fcnt >= 16 && fcnt < 32) ? ch16[31 - fcnt] : 1'b0;
  // ==========================================================
  // Comparison and closing
  task automatic check(input logic [47:0] seen, input logic [47:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard: 19 frames of some 400 clocks each fit well inside it
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  // Configuration pulse counter
  always @(posedge clk_i) if (cfg_pulse_o === 1'b1) cfg_seen <= cfg_seen + 1;
  // Result watcher: each done takes the oldest note
  always @(posedge clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(48'h1, 48'h0, "result without a request");
      end else begin
        got_e = exp_q.pop_front();
        check(48'(data_o), got_e[66:19], "frame data");
        check(48'(cfg_seen), 48'(cfg_want), "config pulses");
        check(48'(chan_o), 48'(got_e[18:16]), "channel");
        check(48'(cmd_o), 48'(got_e[15:0]), "applied command");
        check(48'(busy_o), 48'h0, "conversion busy");
      end
    end
  end
  // ==========================================================
  // One frame: new samples and chain pattern, a command, a refused start mid-frame
  task automatic frame(input logic [15:0] c, input logic [15:0] chw);
    logic [127:0] s;
    logic [15:0] w;
    logic [31:0] d;
    begin
      s = {$urandom, $urandom, $urandom, $urandom};
      w = s[prev_cmd[2:0] * 16 +: 16];
      d = prev_cmd[8] ? {w, 1'b0, prev_cmd[2:0], chw[15:4]} : {w, chw};
      exp_q.push_back({16'h0000, d, prev_cmd[2:0], prev_cmd});
      if (have_prev) cfg_want++;
      @(posedge clk_i);
      sample_i <= s;
      ch16 <= chw;
      start_i <= 1'b1;
      cmd_i <= c;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      start_i <= 1'b1;
      cmd_i <= ~c;
      @(posedge clk_i);
      start_i <= 1'b0;
      while (done_o !== 1'b1) @(posedge clk_i);
      while (ready_o !== 1'b1) @(posedge clk_i);
      prev_cmd = c;
      have_prev = 1'b1;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [15:0] c;
    c = 16'($urandom(6));
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Every channel, both formats, zero and busy chain patterns
    for (int k = 0; k < 9; k++) begin
      c = 16'($urandom);
      c[2:0] = k[2:0];
      c[8] = k[0];
      frame(c, k[1] ? 16'($urandom) : 16'h0000);
    end
    // Second reset between frames drops the pending command
    resetn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(48'(cmd_o), 48'h0, "command after reset");
    check(48'(ready_o), 48'h1, "ready in reset");
    resetn_i <= 1'b1;
    prev_cmd = 16'h0000;
    have_prev = 1'b0;
    repeat (4) @(posedge clk_i);
    for (int k = 0; k < 10; k++) begin
      frame(16'($urandom), 16'($urandom));
    end
    repeat (4) @(posedge clk_i);
    check(48'(exp_q.size()), 48'h0, "results left over");
    wrap_up();
  end
endmodule
`default_nettype wire
